// ===== odsc_top.sv
`include "odsc_regs.svh"
module odsc_top #(
  parameter int NCH   = `ODSC_NCH,
  parameter int CNT_W = `ODSC_CNT_W
) (
  input  wire logic           clk_in,
  input  wire logic           rst_in,
  input  wire logic           sclk_in,
  input  wire logic           select_n_in,
  input  wire logic           sdi_in,
  output logic                sdo_out,
  output logic                sdo_oe_out,
  input  wire logic [NCH-1:0] output_sense_bit_in,
  input  wire logic           overtemp_shutdown_in,
  input  wire logic           logic_supply_in,
  input  wire logic           battery_supply_in,
  output logic [NCH-1:0]      high_side_drive_out,
  output logic                overtemp_fault_out
);
  odsc_pkg::odsc_core_type core_r;
  odsc_pkg::odsc_core_type core_nxt;
  odsc_pkg::odsc_link_type link_r;
  odsc_pkg::odsc_link_type link_nxt;

  logic [NCH-1:0]   sense_s;
  logic             sel_n_s;
  logic             hot_s;
  logic             supply_ok_s;
  logic [CNT_W-1:0] diff;
  logic [CNT_W-1:0] bit_idx;
  logic             frame_ok;

  // sense, overtemp, supply and select pin levels sampled into the system clock domain
  odsc_sync_if #(.W(`ODSC_SYNC_W)) sync_port ();
  assign sync_port.raw = {output_sense_bit_in, overtemp_shutdown_in,
                          logic_supply_in, battery_supply_in, select_n_in};

  odsc_sync #(
    .W       (`ODSC_SYNC_W),
    .RST_VAL (`ODSC_SYNC_RST)
  ) u_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .port   (sync_port.syn)
  );

  assign sense_s     = sync_port.sync[11:4];
  assign hot_s       = sync_port.sync[3];
  assign supply_ok_s = sync_port.sync[2] & sync_port.sync[1];
  assign sel_n_s     = sync_port.sync[0];

  // link domain: counts edges and keeps the last bits received.
  // select is used unsynchronised here; master holds it us around clocking
  always_comb begin
    link_nxt = link_r;
    if (!select_n_in) begin
      link_nxt.cnt = link_r.cnt + 1'b1;
      link_nxt.rx  = {sdi_in, link_r.rx[NCH-1:1]};
    end
  end

  always_ff @(posedge sclk_in or posedge rst_in) begin
    if (rst_in) begin
      link_r <= '{cnt: `ODSC_CNT_RST, rx: `ODSC_CMD_RST};
    end else begin
      link_r <= link_nxt;
    end
  end

  // link counter is quiet while select is high, so it is read as a stable word
  assign diff     = link_r.cnt - core_r.start;
  assign frame_ok = (diff[`ODSC_MOD_W-1:0] == '0);
  assign bit_idx  = diff;

  always_comb begin
    core_nxt = core_r;
    if (hot_s) begin
      core_nxt.fault = 1'b1;
    end
    case (core_r.state)
      odsc_pkg::ODSC_IDLE: begin
        if (!sel_n_s) begin
          core_nxt.start = link_r.cnt;
          // fault image is the inverse of the command: every bit mismatches
          core_nxt.snap  = core_r.fault ? ~core_r.cmd : sense_s;
          core_nxt.state = odsc_pkg::ODSC_FRAME;
        end
      end
      odsc_pkg::ODSC_FRAME: begin
        if (sel_n_s) begin
          if (diff != '0) begin
            core_nxt.cmd = link_r.rx;
          end
          if (frame_ok && !hot_s) begin
            core_nxt.fault = 1'b0;
          end
          core_nxt.state = odsc_pkg::ODSC_IDLE;
        end
      end
      default: begin
        core_nxt.state = odsc_pkg::ODSC_IDLE;
      end
    endcase
    core_nxt.drive = (core_nxt.fault || !supply_ok_s) ? '0 : core_nxt.cmd;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      core_r <= '{state: odsc_pkg::ODSC_IDLE, cmd: `ODSC_CMD_RST, drive: `ODSC_CMD_RST,
                  snap: `ODSC_CMD_RST, start: `ODSC_CNT_RST, fault: 1'b0};
    end else begin
      core_r <= core_nxt;
    end
  end

  // device only answers; it never drives the serial clock
  assign sdo_oe_out = !select_n_in;
  // bit index advances on each rising edge; past the eighth bit it reads zero
  assign sdo_out    = (bit_idx < CNT_W'(NCH)) ? core_r.snap[bit_idx[`ODSC_MOD_W-1:0]] : 1'b0;

  assign high_side_drive_out = core_r.drive;
  assign overtemp_fault_out  = core_r.fault;
endmodule : odsc_top

// ===== odsc_regs.svh
`ifndef ODSC_REGS_SVH
`define ODSC_REGS_SVH
`define ODSC_NCH       8
`define ODSC_CNT_W     8
`define ODSC_MOD_W     3
`define ODSC_CMD_RST   8'h00
`define ODSC_CNT_RST   8'h00
`define ODSC_SYNC_W    12
`define ODSC_SYNC_RST  12'h001
`endif

// ===== odsc_pkg.sv
`include "odsc_regs.svh"
package odsc_pkg;
  typedef enum logic [1:0] {
    ODSC_IDLE  = 2'b01,
    ODSC_FRAME = 2'b10
  } odsc_state_type;

  typedef struct packed {
    odsc_state_type          state;
    logic [`ODSC_NCH-1:0]    cmd;
    logic [`ODSC_NCH-1:0]    drive;
    logic [`ODSC_NCH-1:0]    snap;
    logic [`ODSC_CNT_W-1:0]  start;
    logic                    fault;
  } odsc_core_type;

  typedef struct packed {
    logic [`ODSC_CNT_W-1:0]  cnt;
    logic [`ODSC_NCH-1:0]    rx;
  } odsc_link_type;
endpackage : odsc_pkg

// ===== odsc_sync_if.sv
interface odsc_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport src (output raw, input sync);
  modport syn (input raw, output sync);
endinterface : odsc_sync_if

// ===== odsc_sync.sv
module odsc_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  odsc_sync_if.syn  port
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= port.raw;
      sync_r <= meta_r;
    end
  end

  assign port.sync = sync_r;
endmodule : odsc_sync

// ===== odsc_checker.sv
module odsc_checker #(parameter int NCH = 8) (
  input wire logic           clk_in,
  input wire logic           rst_in,
  input wire logic           select_n_in,
  input wire logic           sdo_out,
  input wire logic           sdo_oe_out,
  input wire logic [NCH-1:0] output_sense_bit_in,
  input wire logic           overtemp_shutdown_in,
  input wire logic           logic_supply_in,
  input wire logic           battery_supply_in,
  input wire logic [NCH-1:0] high_side_drive_out,
  input wire logic           overtemp_fault_out
);
  wire logic           s  = select_n_in;
  wire logic           f  = overtemp_fault_out;
  wire logic           h  = overtemp_shutdown_in;
  wire logic           pw = logic_supply_in && battery_supply_in;
  wire logic [NCH-1:0] dr = high_side_drive_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_open;
    $fell(s) ##1 !s [*5];
  endsequence
  AST_OE: assert property (sdo_oe_out == !s) else $error("oe");
  AST_PWR: assert property (!pw [*5] |-> dr == 0) else $error("pwr");
  AST_HOT: assert property (h [*5] |-> f && dr == 0) else $error("hot");
  AST_FDR: assert property (f [*2] |-> dr == 0) else $error("fdr");
  AST_KEEP: assert property (s [*8] ##0 f |=> f) else $error("keep");
  AST_SDO: assert property (s_open ##0 !f && $stable(output_sense_bit_in) |-> sdo_out == output_sense_bit_in[0]) else $error("sdo");
  AST_LOW: assert property ((!s && pw && !h) [*6] |-> $stable(dr)) else $error("low");
  AST_HIGH: assert property ((s && pw && !h) [*8] |-> $stable(dr)) else $error("high");
endmodule : odsc_checker
bind odsc_top odsc_checker #(.NCH(NCH)) odsc_checker_inst (.*);

// ===== odsc_master.sv
module odsc_master (
  output logic     sclk_out     = 1'b1,
  output logic     select_n_out = 1'b1,
  output logic     sdi_out      = 1'b0,
  input wire logic sdo_in
);
  timeunit 1ns / 1ps;
  task automatic xfer(input int n, input logic [15:0] d, output logic [15:0] q);
    q = '0;
    select_n_out = 1'b0;
    #3000;
    for (int i = 0; i < n; i++) begin
      sclk_out = 1'b0;
      sdi_out = d[i];
      #6 q[i] = sdo_in;
      sclk_out = 1'b1;
      #6;
    end
    #1000;
    select_n_out = 1'b1;
    sdi_out = ~sdi_out;
    #300;
  endtask : xfer
endmodule : odsc_master

// ===== odsc_tb_top.sv
module odsc_tb_top;
  timeunit 1ns / 1ps;
  logic clk_in = 0, rst_in = 1, hot = 0, lsup = 1, bsup = 1;
  logic [7:0] flip = 0, sense = 0, drv, cmd, want = 8'h00;
  logic [15:0] d, q;
  wire logic sclk, sel_n, sdi, sdo, oe, fault;
  int failures = 0, n_tests = 0, seed = 32'h5260_4b00;
`define CHK(n, e, s) begin n_tests++; if ((e) !== (s)) begin failures++; $display("BAD %s exp %h got %h", n, e, s); end end
  odsc_top odsc_top_inst (.clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk), .select_n_in(sel_n), .sdi_in(sdi),
    .sdo_out(sdo), .sdo_oe_out(oe), .output_sense_bit_in(sense), .overtemp_shutdown_in(hot),
    .logic_supply_in(lsup), .battery_supply_in(bsup), .high_side_drive_out(drv), .overtemp_fault_out(fault));
  odsc_master odsc_master_inst (.sclk_out(sclk), .select_n_out(sel_n), .sdi_out(sdi), .sdo_in(oe ? sdo : 1'bz));
  initial forever #5 clk_in = ~clk_in;
  // pins follow drivers, with random shorts injected through flip
  always @(posedge clk_in) sense <= drv ^ flip;
  function automatic logic [7:0] last8(input logic [15:0] v, input int n);
    return v[n-1 -: 8];
  endfunction : last8
  task automatic w(input int n);
    repeat (n) @(posedge clk_in);
  endtask : w
  task automatic xf(input int n);
    logic [15:0] prev;
    prev = d;
    d = 16'($random(seed));
    if (d === prev) #300000;
    odsc_master_inst.xfer(n, d, q);
  endtask : xf
  task automatic summarize;
    if (failures == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  initial begin
    #500000;
    failures++;
    summarize();
  end
  initial begin
    w(2);
    rst_in <= 1'b0;
    w(3);
    `CHK("rst", 9'h000, {fault, drv})
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_in) flip <= 8'($random(seed)) & {8{i[0]}};
      w(4);
      cmd = want ^ flip;
      xf(8);
      `CHK("sense", cmd, q[7:0])
      want = last8(d, 8);
      `CHK("drive", want, drv)
    end
    xf(16);
    want = last8(d, 16);
    `CHK("drv16", want, drv)
    cmd = want;
    @(posedge clk_in) hot <= 1'b1;
    w(6);
    `CHK("hot", 9'h100, {fault, drv})
    xf(8);
    `CHK("image", ~cmd, q[7:0])
    @(posedge clk_in) hot <= 1'b0;
    xf(7);
    `CHK("f7", 1'b1, fault)
    xf(8);
    `CHK("clr", {1'b0, d[7:0]}, {fault, drv})
    for (int k = 1; k < 3; k++) begin
      @(posedge clk_in) {lsup, bsup} <= 2'(k);
      w(6);
      `CHK("pwr", 8'h00, drv)
      @(posedge clk_in) {lsup, bsup} <= 2'b11;
      w(6);
      `CHK("back", d[7:0], drv)
    end
    summarize();
  end
endmodule : odsc_tb_top
